/* hdl/sstx_defs.svh */
// Offsets, field positions, codes and timing counts of the frame and slow-channel transmitter
`ifndef SSTX_DEFS_SVH
`define SSTX_DEFS_SVH

`define SSTX_CLK_PERIOD_NS     10
`define SSTX_TICK_MIN_NS       500
`define SSTX_TICK_STEP_NS      250
`define SSTX_TICK_BASE_CYC     (`SSTX_TICK_MIN_NS / `SSTX_CLK_PERIOD_NS)
`define SSTX_TICK_STEP_CYC     (`SSTX_TICK_STEP_NS / `SSTX_CLK_PERIOD_NS)

`define SSTX_LOW_TICKS         16'h0005
`define SSTX_PAUSE_MIN_TICKS   16'h000c
`define SSTX_SYNC_TICKS        16'h0038
`define SSTX_NIB_BASE_TICKS    16'h000c
`define SSTX_SLOW_LAST_FRAME   5'h11
`define SSTX_SEQ_LAST          4'hb

`define SSTX_CFGA_LATCH_BIT    2
`define SSTX_CFGA_STARTUP_BIT  4
`define SSTX_CFGB_TICK_MSB     11
`define SSTX_CFGB_TICK_LSB     8
`define SSTX_CFGB_TYPE_MSB     14
`define SSTX_CFGB_TYPE_LSB     13

`define SSTX_ID_DIAG           8'h01
`define SSTX_ID_TYPE           8'h03
`define SSTX_ID_SN1_HI         8'h29
`define SSTX_ID_SN1_LO         8'h2a
`define SSTX_ID_SN2_HI         8'h2b
`define SSTX_ID_SN2_LO         8'h2c
`define SSTX_ID_MFR            8'h05
`define SSTX_ID_REV            8'h06
`define SSTX_ID_TEMP           8'h23
`define SSTX_ID_FIELD          8'h1c

`define SSTX_PROTO_REV         12'h004
`define SSTX_DIAG_FIXED        12'h800
`define SSTX_STARTUP_ALT       12'hffe

`define SSTX_TYPE_NONE         12'h050
`define SSTX_TYPE_DUAL_LIN     12'h056
`define SSTX_TYPE_DUAL_ANG     12'h065
`define SSTX_TYPE_DUAL_REL     12'h075
`define SSTX_TYPE_ONE_LIN      12'h051
`define SSTX_TYPE_ONE_ANG      12'h060
`define SSTX_TYPE_ONE_REL      12'h070
`define SSTX_TYPE_SEC_LIN      12'h055
`define SSTX_TYPE_SEC_ANG      12'h064
`define SSTX_TYPE_SEC_REL      12'h074

`define SSTX_CRC4_SEED         4'h5
`define SSTX_CRC4_POLY         4'hd
`define SSTX_CRC6_SEED         6'h15
`define SSTX_CRC6_POLY         6'h19

`endif

/* hdl/sstx_pkg.sv */
// Types shared by the frame and slow-channel transmitter
package sstx_pkg;

  typedef enum logic [1:0] {
    FMT_SIX_DUAL     = 2'b00,
    FMT_THREE_SINGLE = 2'b01,
    FMT_SIX_SECURE   = 2'b10,
    FMT_RESERVED     = 2'b11
  } sstx_fmt_e;

  typedef enum logic [1:0] {
    ST_IDLE  = 2'b00,
    ST_SYNC  = 2'b01,
    ST_NIB   = 2'b10,
    ST_PAUSE = 2'b11
  } sstx_state_e;

endpackage

/* hdl/sstx_stream_if.sv */
// Valid/ready stream carrying position samples between the buffer and the frame engine
`timescale 1ns/100ps
interface sstx_stream_if #(parameter int W = 25) ();
  logic         valid;
  logic         ready;
  logic [W-1:0] data;
  modport src (output valid, output data, input ready);
  modport snk (input valid, input data, output ready);
endinterface

/* hdl/sstx_buf.sv */
// Two-entry sample buffer with valid and ready on both sides
`timescale 1ns/100ps
module sstx_buf #(
  parameter int W     = 25,
  parameter int DEPTH = 2
) (
  // Clock and reset
  input  wire logic   clk_i,
  input  wire logic   rst_i,
  // Streams
  sstx_stream_if.snk  in_s,
  sstx_stream_if.src  out_m
);
  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

  logic [W-1:0]  mem_reg  [DEPTH];
  logic [W-1:0]  mem_next [DEPTH];
  logic [AW-1:0] wp_reg;
  logic [AW-1:0] wp_next;
  logic [AW-1:0] rp_reg;
  logic [AW-1:0] rp_next;
  logic [AW:0]   cnt_reg;
  logic [AW:0]   cnt_next;
  logic          push;
  logic          pop;

  assign in_s.ready  = (cnt_reg != (AW+1)'(DEPTH));
  assign out_m.valid = (cnt_reg != '0);
  assign out_m.data  = mem_reg[rp_reg];

  always_comb begin
    push     = in_s.valid && in_s.ready;
    pop      = out_m.valid && out_m.ready;
    mem_next = mem_reg;
    wp_next  = wp_reg;
    rp_next  = rp_reg;
    cnt_next = cnt_reg;
    if (push) begin
      mem_next[wp_reg] = in_s.data;
      wp_next          = (wp_reg == AW'(DEPTH - 1)) ? '0 : wp_reg + AW'(1);
    end
    if (pop) begin
      rp_next = (rp_reg == AW'(DEPTH - 1)) ? '0 : rp_reg + AW'(1);
    end
    if (push && !pop) begin
      cnt_next = cnt_reg + (AW+1)'(1);
    end else if (pop && !push) begin
      cnt_next = cnt_reg - (AW+1)'(1);
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wp_reg  <= '0;
      rp_reg  <= '0;
      cnt_reg <= '0;
    end else begin
      wp_reg  <= wp_next;
      rp_reg  <= rp_next;
      cnt_reg <= cnt_next;
    end
  end

  // Storage needs no reset: entries are only read once counted
  always_ff @(posedge clk_i) begin
    mem_reg <= mem_next;
  end
endmodule

/* hdl/sstx_top.sv */
// Single-wire frame transmitter with slow-channel message sequencer and tick timing
`timescale 1ns/100ps
`include "sstx_defs.svh"

// Operation
// - Diagnostic status travels on the slow channel under identifier 01h.
// - Diagnostic code always lies between 800h and 87Fh.
// - Code bits 0..3: memory, signal path, regulator, field amplitude faults.
// - Bits 4..6: temperature invalid, over/underflow, over-voltage; 7..10 zero; 11 one.
// - Sensor-type message selected by bits 14:13 of the second setup word.
// - Type 00 sends 050h; dual-channel six-nibble sends 056h, 065h, 075h.
// - Three-nibble single-channel format sends 051h, 060h, 070h.
// - Six-nibble secure format sends 055h, 064h, 074h.
// - Standard start-up sends zero data until the first valid measurement.
// - Alternative start-up, chosen by setup bit 4, sends 4094 until valid data.
// - Exactly one frame is emitted per position sample.
// - Frame data comes from the oldest buffered sample, taken at frame start.
// - Tick period 0.5 us plus 0.25 us per step of the tick selection code.
// - Tick selection comes from bits 11:8 of the second setup word.
// - Every pulse opens with a low phase of exactly five ticks.
// - The closing pause lasts at least twelve ticks.
// - Pause length adapts so the frame period equals frame_period_ticks_i whenever that leaves at least twelve pause ticks.
// - Slow messages use enhanced format, configuration bit zero, 12-bit data, 8-bit id.
// - Fixed twelve-message sequence with diagnostics in slots four, eight, twelve.
module sstx_top
  import sstx_pkg::*;
#(
  parameter logic [11:0] MFR_CODE = 12'h0a5  // Arbitrary neutral value
) (
  // Clock and reset
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  // Configuration
  input  wire logic [15:0] config_word_a_i,
  input  wire logic [15:0] config_word_b_i,
  input  wire logic [1:0]  format_i,
  input  wire logic [15:0] frame_period_ticks_i,
  // Position samples
  input  wire logic        sample_valid_i,
  output logic             sample_ready_o,
  input  wire logic [23:0] sample_data_i,
  input  wire logic        sample_ok_i,
  // Slow-channel sources
  input  wire logic [6:0]  err_i,
  input  wire logic [15:0] serial_id1_i,
  input  wire logic [15:0] serial_id2_i,
  input  wire logic [11:0] temp_i,
  input  wire logic [11:0] field_i,
  // Line and status
  output logic             sent_out_o,
  output logic             sent_oe_n_o,
  output logic             frame_start_o,
  output logic             started_o
);

  sstx_stream_if #(.W(25)) in_if ();
  sstx_stream_if #(.W(25)) eng_if ();

  sstx_state_e state_reg, state_next;
  logic [8:0]  cyc_reg, cyc_next;
  logic [15:0] tick_reg, tick_next;
  logic [15:0] len_reg, len_next;
  logic [2:0]  nib_reg, nib_next;
  logic [15:0] used_reg, used_next;
  logic [23:0] word_reg, word_next;
  logic [3:0]  crc_reg, crc_next;
  logic [3:0]  stat_reg, stat_next;
  logic [4:0]  bit_reg, bit_next;
  logic [3:0]  msg_reg, msg_next;
  logic [7:0]  sid_reg, sid_next;
  logic [11:0] sdat_reg, sdat_next;
  logic [5:0]  scrc_reg, scrc_next;
  logic        started_reg, started_next;
  logic        start_reg, start_next;
  logic        line_reg, line_next;
  logic [6:0]  diag_reg, diag_next;

  logic [8:0]  tick_len;
  logic        tick_end;
  logic        pulse_end;
  logic [2:0]  n_data;
  logic        latch_on;
  logic [7:0]  tab_id;
  logic [11:0] tab_dat;
  logic [23:0] startup_word;
  logic [16:0] used_sum;
  logic [2:0]  nib_nx;
  logic [3:0]  nib_val;

  assign in_if.valid    = sample_valid_i;
  assign in_if.data     = {sample_ok_i, sample_data_i};
  assign sample_ready_o = in_if.ready;

  sstx_buf #(.W(25), .DEPTH(2)) u_buf (
    .clk_i (clk_i),
    .rst_i (rst_i),
    .in_s  (in_if),
    .out_m (eng_if)
  );

  // Bit 3 of the status nibble for slow frame k
  function automatic logic slow_b3(input logic [4:0] k, input logic [7:0] id);
    logic r;
    r = 1'b0;
    if (k < 5'd6) begin
      r = 1'b1;
    end else if (k >= 5'd8 && k <= 5'd11) begin
      r = id[15 - int'(k)];
    end else if (k >= 5'd13 && k <= 5'd16) begin
      r = id[16 - int'(k)];
    end
    return r;
  endfunction

  // Bit 2 of the status nibble: CRC first, then data MSB first
  function automatic logic slow_b2(input logic [4:0] k, input logic [11:0] d,
                                   input logic [5:0] c);
    logic r;
    if (k < 5'd6) begin
      r = c[5 - int'(k)];
    end else begin
      r = d[17 - int'(k)];
    end
    return r;
  endfunction

  // Slow-channel CRC over the 24 message bits, augmented by six zeros
  function automatic logic [5:0] crc6(input logic [7:0] id, input logic [11:0] d);
    logic [29:0] s;
    logic [5:0]  c;
    logic        fb;
    s = '0;
    for (int k = 6; k < 18; k++) begin
      s[29 - 2*(k-6)] = slow_b3(5'(k), id);
      s[28 - 2*(k-6)] = d[17 - k];
    end
    c = `SSTX_CRC6_SEED;
    for (int i = 29; i >= 0; i--) begin
      fb = c[5];
      c  = {c[4:0], s[i]};
      if (fb) begin
        c = c ^ `SSTX_CRC6_POLY;
      end
    end
    return c;
  endfunction

  // Frame CRC over n data nibbles, MSB first, with one zero nibble appended
  function automatic logic [3:0] crc4(input logic [23:0] w, input logic [2:0] n);
    logic [3:0] c;
    logic [3:0] r;
    c = `SSTX_CRC4_SEED;
    for (int i = 0; i <= 6; i++) begin
      if (i <= int'(n)) begin
        r = c;
        for (int b = 0; b < 4; b++) begin
          r = r[3] ? ({r[2:0], 1'b0} ^ `SSTX_CRC4_POLY) : {r[2:0], 1'b0};
        end
        c = (i == int'(n)) ? r : r ^ 4'(w >> (20 - 4*i));
      end
    end
    return c;
  endfunction

  function automatic logic [11:0] sensor_type(input logic [1:0] fmt, input logic [1:0] sel);
    logic [11:0] v;
    v = `SSTX_TYPE_NONE;
    if (sel != 2'b00) begin
      unique case (fmt)
        FMT_THREE_SINGLE: v = (sel == 2'b01) ? `SSTX_TYPE_ONE_LIN :
                              (sel == 2'b10) ? `SSTX_TYPE_ONE_ANG :
                                               `SSTX_TYPE_ONE_REL;
        FMT_SIX_SECURE:   v = (sel == 2'b01) ? `SSTX_TYPE_SEC_LIN :
                              (sel == 2'b10) ? `SSTX_TYPE_SEC_ANG :
                                               `SSTX_TYPE_SEC_REL;
        default:          v = (sel == 2'b01) ? `SSTX_TYPE_DUAL_LIN :
                              (sel == 2'b10) ? `SSTX_TYPE_DUAL_ANG :
                                               `SSTX_TYPE_DUAL_REL;
      endcase
    end
    return v;
  endfunction

  // Twelve-slot slow message sequence
  always_comb begin
    tab_id  = `SSTX_ID_DIAG;
    tab_dat = `SSTX_DIAG_FIXED | {5'h00, diag_reg};
    unique case (msg_reg)
      4'h0: begin
        tab_id  = `SSTX_ID_TYPE;
        tab_dat = sensor_type(format_i,
                  config_word_b_i[`SSTX_CFGB_TYPE_MSB:`SSTX_CFGB_TYPE_LSB]);
      end
      4'h1: begin tab_id = `SSTX_ID_SN1_HI; tab_dat = {4'h0, serial_id1_i[15:8]}; end
      4'h2: begin tab_id = `SSTX_ID_SN1_LO; tab_dat = {4'h0, serial_id1_i[7:0]}; end
      4'h4: begin tab_id = `SSTX_ID_SN2_HI; tab_dat = {4'h0, serial_id2_i[15:8]}; end
      4'h5: begin tab_id = `SSTX_ID_SN2_LO; tab_dat = {4'h0, serial_id2_i[7:0]}; end
      4'h6: begin tab_id = `SSTX_ID_MFR;    tab_dat = MFR_CODE;                   end
      4'h8: begin tab_id = `SSTX_ID_REV;    tab_dat = `SSTX_PROTO_REV;            end
      4'h9: begin tab_id = `SSTX_ID_TEMP;   tab_dat = temp_i;                     end
      4'ha: begin tab_id = `SSTX_ID_FIELD;  tab_dat = field_i;                    end
      default: begin
        tab_id  = `SSTX_ID_DIAG;
        tab_dat = `SSTX_DIAG_FIXED | {5'h00, diag_reg};
      end
    endcase
  end

  assign tick_len = 9'(`SSTX_TICK_BASE_CYC) + 9'(`SSTX_TICK_STEP_CYC) *
                    {5'h00, config_word_b_i[`SSTX_CFGB_TICK_MSB:`SSTX_CFGB_TICK_LSB]};
  assign tick_end     = (cyc_reg >= tick_len - 9'h001);
  assign pulse_end    = tick_end && (tick_reg == len_reg - 16'h0001);
  assign n_data       = (format_i == FMT_THREE_SINGLE) ? 3'h3 : 3'h6;
  assign latch_on     = config_word_a_i[`SSTX_CFGA_LATCH_BIT];
  assign startup_word = config_word_a_i[`SSTX_CFGA_STARTUP_BIT] ?
                        {`SSTX_STARTUP_ALT, `SSTX_STARTUP_ALT} : 24'h000000;
  assign used_sum     = {1'b0, used_reg} + {1'b0, len_reg};
  assign nib_nx       = nib_reg + 3'h1;
  assign nib_val      = (nib_nx == n_data + 3'h1) ? crc_reg :
                        4'(word_reg >> (5'd4 * (5'd6 - {2'b00, nib_nx})));

  always_comb begin
    state_next   = state_reg;
    cyc_next     = cyc_reg + 9'h001;
    tick_next    = tick_reg;
    len_next     = len_reg;
    nib_next     = nib_reg;
    used_next    = used_reg;
    word_next    = word_reg;
    crc_next     = crc_reg;
    stat_next    = stat_reg;
    bit_next     = bit_reg;
    msg_next     = msg_reg;
    sid_next     = sid_reg;
    sdat_next    = sdat_reg;
    scrc_next    = scrc_reg;
    started_next = started_reg;
    start_next   = 1'b0;
    eng_if.ready = 1'b0;
    // Latched faults stay until reported; a fault in the reporting cycle is kept
    diag_next    = latch_on ? (diag_reg | err_i) : err_i;
    if (tick_end) begin
      cyc_next  = '0;
      tick_next = tick_reg + 16'h0001;
    end
    unique case (state_reg)
      ST_IDLE: begin
        cyc_next  = '0;
        tick_next = '0;
        if (eng_if.valid) begin
          eng_if.ready = 1'b1;
          start_next   = 1'b1;
          started_next = started_reg | eng_if.data[24];
          word_next    = (eng_if.data[24] || started_reg) ?
                         eng_if.data[23:0] : startup_word;
          crc_next     = crc4(word_next, n_data);
          if (bit_reg == 5'h00) begin
            sid_next  = tab_id;
            sdat_next = tab_dat;
            scrc_next = crc6(tab_id, tab_dat);
            if (tab_id == `SSTX_ID_DIAG && latch_on) begin
              diag_next = err_i;
            end
          end
          stat_next = {slow_b3(bit_reg, sid_next),
                       slow_b2(bit_reg, sdat_next, scrc_next), 2'b00};
          if (bit_reg == `SSTX_SLOW_LAST_FRAME) begin
            bit_next = '0;
            msg_next = (msg_reg == `SSTX_SEQ_LAST) ? 4'h0 : msg_reg + 4'h1;
          end else begin
            bit_next = bit_reg + 5'h01;
          end
          state_next = ST_SYNC;
          len_next   = `SSTX_SYNC_TICKS;
          used_next  = `SSTX_SYNC_TICKS;
        end
      end
      ST_SYNC: begin
        if (pulse_end) begin
          state_next = ST_NIB;
          nib_next   = 3'h0;
          tick_next  = '0;
          len_next   = `SSTX_NIB_BASE_TICKS + {12'h000, stat_reg};
        end
      end
      ST_NIB: begin
        if (pulse_end) begin
          tick_next = '0;
          used_next = used_sum[15:0];
          if (nib_reg == n_data + 3'h1) begin
            state_next = ST_PAUSE;
            if ({1'b0, frame_period_ticks_i} >= used_sum + {1'b0, `SSTX_PAUSE_MIN_TICKS}) begin
              len_next = frame_period_ticks_i - used_sum[15:0];
            end else begin
              len_next = `SSTX_PAUSE_MIN_TICKS;
            end
          end else begin
            nib_next = nib_nx;
            len_next = `SSTX_NIB_BASE_TICKS + {12'h000, nib_val};
          end
        end
      end
      ST_PAUSE: begin
        if (pulse_end) begin
          state_next = ST_IDLE;
        end
      end
    endcase
    line_next = !((state_next != ST_IDLE) && (tick_next < `SSTX_LOW_TICKS));
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state_reg   <= ST_IDLE;
      cyc_reg     <= '0;
      tick_reg    <= '0;
      len_reg     <= '0;
      nib_reg     <= '0;
      used_reg    <= '0;
      word_reg    <= '0;
      crc_reg     <= '0;
      stat_reg    <= '0;
      bit_reg     <= '0;
      msg_reg     <= '0;
      sid_reg     <= '0;
      sdat_reg    <= '0;
      scrc_reg    <= '0;
      started_reg <= 1'b0;
      start_reg   <= 1'b0;
      line_reg    <= 1'b1;
      diag_reg    <= '0;
    end else begin
      state_reg   <= state_next;
      cyc_reg     <= cyc_next;
      tick_reg    <= tick_next;
      len_reg     <= len_next;
      nib_reg     <= nib_next;
      used_reg    <= used_next;
      word_reg    <= word_next;
      crc_reg     <= crc_next;
      stat_reg    <= stat_next;
      bit_reg     <= bit_next;
      msg_reg     <= msg_next;
      sid_reg     <= sid_next;
      sdat_reg    <= sdat_next;
      scrc_reg    <= scrc_next;
      started_reg <= started_next;
      start_reg   <= start_next;
      line_reg    <= line_next;
      diag_reg    <= diag_next;
    end
  end

  assign sent_out_o    = line_reg;
  assign sent_oe_n_o   = 1'b0;
  assign frame_start_o = start_reg;
  assign started_o     = started_reg;

endmodule

/* verif/sstx_rx_model.sv */
// Receiver model: measures every line pulse in ticks, falling edge to falling edge
`timescale 1ns/100ps
module sstx_rx_model (
  // Clock and reset
  input  wire logic clk_i,
  input  wire logic rst_i,
  // Line and tick length in clock cycles
  input  wire logic line_i,
  input  var  int   tick_cyc_i
);
  int   pulses[$];
  int   cnt;
  logic line_q;

  // The first entry after reset is the idle time before the first frame
  always @(posedge clk_i) begin
    if (rst_i) begin
      pulses.delete();
      cnt    = 0;
      line_q = 1'b1;
    end else begin
      cnt++;
      if (line_q && !line_i) begin
        pulses.push_back((cnt + tick_cyc_i / 2) / tick_cyc_i);
        cnt = 0;
      end
      line_q = line_i;
    end
  end
endmodule

/* verif/sstx_top_chk.sv */
// Port-level assertions for the frame transmitter
`timescale 1ns/100ps
module sstx_top_chk (
  // Clock and reset
  input wire logic        clk_i,
  input wire logic        rst_i,
  // Observed ports
  input wire logic [15:0] config_word_b_i,
  input wire logic        sample_ready_o,
  input wire logic        sent_out_o,
  input wire logic        sent_oe_n_o,
  input wire logic        frame_start_o,
  input wire logic        started_o
);
  int   tc;
  int   low_cnt;
  int   gap_cnt;
  logic line_q;
  logic sync_q;
  logic seen_q;
  logic fell;

  // Tick length in clock cycles for the selected code
  assign tc   = 50 + 25 * int'(config_word_b_i[11:8]);
  assign fell = line_q & ~sent_out_o;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      low_cnt <= 0;
      gap_cnt <= 0;
      line_q  <= 1'b1;
      sync_q  <= 1'b0;
      seen_q  <= 1'b0;
    end else begin
      low_cnt <= sent_out_o ? 0 : low_cnt + 1;
      gap_cnt <= fell ? 1 : gap_cnt + 1;
      line_q  <= sent_out_o;
      sync_q  <= frame_start_o ? 1'b1 : (fell ? 1'b0 : sync_q);
      seen_q  <= seen_q | fell;
    end
  end

  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);

  a_rst_idle: assert property ($fell(rst_i) |-> sample_ready_o && sent_out_o
    && !frame_start_o && !started_o) else $error("outputs not idle after reset");
  a_oe_drive: assert property (sent_oe_n_o == 1'b0) else $error("line not driven");
  a_fs_pulse: assert property (frame_start_o |=> !frame_start_o)
    else $error("frame start longer than one cycle");
  a_fs_idle: assert property (frame_start_o |-> $fell(sent_out_o) && !sync_q)
    else $error("frame start without line fall");
  a_low_width: assert property ($rose(sent_out_o) |-> low_cnt == 5 * tc)
    else $error("low phase not five ticks");
  a_gap_min: assert property (fell && seen_q |-> gap_cnt >= 12 * tc)
    else $error("pulse shorter than twelve ticks");
  a_sync_len: assert property (fell && sync_q |-> gap_cnt == 56 * tc)
    else $error("sync pulse length wrong");
  a_started_hold: assert property (started_o |=> started_o)
    else $error("started flag dropped");
endmodule

bind sstx_top sstx_top_chk u_chk (
  .clk_i           (clk_i),
  .rst_i           (rst_i),
  .config_word_b_i (config_word_b_i),
  .sample_ready_o  (sample_ready_o),
  .sent_out_o      (sent_out_o),
  .sent_oe_n_o     (sent_oe_n_o),
  .frame_start_o   (frame_start_o),
  .started_o       (started_o)
);

/* verif/sstx_top_tb_top.sv */
// Self-checking bench for the frame transmitter
`timescale 1ns/100ps
module sstx_top_tb_top;
  logic        clk_i   = 1'b0;
  logic        rst_i   = 1'b1;
  logic [15:0] cfg_a   = 16'h0004;
  logic [15:0] cfg_b   = 16'h4000;
  logic [1:0]  fmt     = 2'b01;
  logic [15:0] period  = 16'h0000;
  logic        s_valid = 1'b0;
  logic [23:0] s_data  = 24'h000000;
  logic        s_ok    = 1'b0;
  logic [6:0]  err     = 7'h00;
  logic        s_ready;
  logic        line;
  logic        fstart;
  logic        started;
  int          tc      = 50;
  int          starts[$];
  int          fidx    = 0;
  int          failures = 0;
  int          checks   = 0;

  always #5 clk_i = ~clk_i;

  sstx_top dut (
    .clk_i                (clk_i),
    .rst_i                (rst_i),
    .config_word_a_i      (cfg_a),
    .config_word_b_i      (cfg_b),
    .format_i             (fmt),
    .frame_period_ticks_i (period),
    .sample_valid_i       (s_valid),
    .sample_ready_o       (s_ready),
    .sample_data_i        (s_data),
    .sample_ok_i          (s_ok),
    .err_i                (err),
    .serial_id1_i         (16'h1234),
    .serial_id2_i         (16'h5678),
    .temp_i               (12'h3c0),
    .field_i              (12'h2a0),
    .sent_out_o           (line),
    .sent_oe_n_o          (),
    .frame_start_o        (fstart),
    .started_o            (started)
  );

  sstx_rx_model rx (
    .clk_i      (clk_i),
    .rst_i      (rst_i),
    .line_i     (line),
    .tick_cyc_i (tc)
  );

  // Pulse index at each frame start; the sync pulse is the next entry
  always @(negedge clk_i) begin
    if (fstart === 1'b1) starts.push_back(rx.pulses.size());
  end

  task automatic finish_test();
    $display("checks %0d failures %0d", checks, failures);
    if (failures == 0 && checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  task automatic chk(string nm, logic [31:0] exp, logic [31:0] got);
    checks++;
    if (exp !== got) begin
      failures++;
      $display("[ERR] %s expected %0h seen %0h", nm, exp, got);
    end
  endtask

  task automatic push(logic [23:0] d, logic ok);
    @(negedge clk_i);
    s_valid = 1'b1;
    s_data  = d;
    s_ok    = ok;
    while (s_ready !== 1'b1) @(negedge clk_i);
    @(negedge clk_i);
    s_valid = 1'b0;
  endtask

  // Frame of nn data nibbles: sync, status, data, check, pause
  task automatic frame(string nm, logic [23:0] dat, int nn, logic [3:0] stx, int per);
    int i0;
    int sum;
    sum = 0;
    while (starts.size() <= fidx) @(negedge clk_i);
    i0 = starts[fidx] + 1;
    fidx++;
    while (rx.pulses.size() < i0 + 3 + nn + int'(per >= 0)) @(negedge clk_i);
    chk({nm, " sync"}, 56, rx.pulses[i0]);
    chk({nm, " status"}, stx, (rx.pulses[i0+1] - 12) & 11);
    for (int k = 0; k < nn; k++) begin
      chk({nm, " data"}, dat[23-4*k -: 4], rx.pulses[i0+2+k] - 12);
    end
    if (per == 0) chk({nm, " pause"}, 12, rx.pulses[i0+3+nn]);
    if (per > 0) begin
      for (int k = 0; k < 4 + nn; k++) sum += rx.pulses[i0+k];
      chk({nm, " period"}, per, sum);
    end
    $display("test %s done", nm);
  endtask

  initial begin
    repeat (95000) @(posedge clk_i);
    failures++;
    $display("[ERR] watchdog expected done seen timeout");
    finish_test();
  end

  initial begin
    repeat (16) @(negedge clk_i);
    rst_i = 1'b0;
    chk("ready idle", 1, s_ready);
    push(24'habc123, 1'b0);
    push(24'h456789, 1'b0);
    frame("zero start", 24'h000000, 3, 4'h8, 0);
    frame("zero hold", 24'h000000, 3, 4'h8, -1);
    chk("started low", 0, started);
    cfg_a  = 16'h0014;
    period = 16'd220;
    push(24'h111111, 1'b0);
    push(24'h5a7000, 1'b1);
    frame("alt start", 24'hffe000, 3, 4'h8, 220);
    frame("first valid", 24'h5a7000, 3, 4'h8, -1);
    chk("started high", 1, started);
    push(24'h2c4000, 1'b1);
    push(24'he1f000, 1'b1);
    chk("ready full", 0, s_ready);
    err = 7'h05;
    frame("queue one", 24'h2c4000, 3, 4'h8, 220);
    frame("queue two", 24'he1f000, 3, 4'h8, -1);
    // Remaining pause of the last queued frame is at most 66 ticks
    repeat (3500) @(negedge clk_i);
    cfg_b  = 16'h4100;
    period = 16'h0000;
    tc     = 75;
    push(24'h0f0000, 1'b1);
    frame("tick step", 24'h0f0000, 3, 4'h0, -1);
    // Twelve-tick pause at 75 cycles a tick ends within 900 cycles
    repeat (1200) @(negedge clk_i);
    cfg_b = 16'h4000;
    fmt   = 2'b00;
    tc    = 50;
    push(24'h102304, 1'b1);
    frame("six nibble", 24'h102304, 6, 4'h0, -1);
    finish_test();
  end
endmodule
